// [src/imr_pkg.sv]
// Purpose: Shared constants and types for the I2C master byte receiver
// Assumes: 8-bit register port, 3-bit word address
// Notes:   All offsets, field positions and reset values live here
package imr_pkg;

  // ---------------------------------------------------------------
  // Register port geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL = 3'h0; // serial_control_two
  localparam logic [2:0] OFS_BUF  = 3'h1; // transfer_buffer
  localparam logic [2:0] OFS_STAT = 3'h2; // Sticky status, write one to clear
  localparam logic [2:0] OFS_MASK = 3'h3; // Interrupt mask, status layout
  localparam logic [2:0] OFS_BRG  = 3'h4; // Baud rate reload value

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_RECEIVE_ENABLE_BIT   = 3; // receive_enable_bit
  localparam int unsigned CTRL_ACK_SEQUENCE_ENABLE  = 4; // ack_sequence_enable
  localparam int unsigned CTRL_ACKVAL = 5; // Level sent in the ack slot
  localparam int unsigned STAT_BF     = 0; // buffer_full_flag, read only
  localparam int unsigned STAT_IRQ    = 1; // serial_irq_flag
  localparam int unsigned STAT_OVF    = 2; // receive_overflow_flag
  localparam int unsigned STAT_WRITE_COLLISION_FLAG   = 3; // write_collision_flag
  localparam int unsigned STAT_BUSY   = 4; // Module not idle, read only

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BRG   = 8'h31;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [2:0] LAST_BIT  = 3'h7; // Index of eighth bit
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RX_LOW   = 3'b001,
    ST_RX_HIGH  = 3'b010,
    ST_ACK_LOW  = 3'b011,
    ST_ACK_HIGH = 3'b100,
    ST_ACK_END  = 3'b101
  } imr_state_t;

endpackage : imr_pkg

// [src/imr_brg.sv]
// Purpose: Baud rate generator, one tick per half SCL period
// Assumes: reload is stable while run is high
// Notes:   A half period lasts reload+1 clock cycles
`timescale 1ns/1ps
`default_nettype none
module imr_brg #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] reload,
  // Rollover pulse
  output var  logic         tick
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (W < 2 || W > 16) begin : g_bad_width
    $error("imr_brg: W must lie between 2 and 16");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } imr_brg_regs_t;

  imr_brg_regs_t r_reg;
  imr_brg_regs_t r_next;

  // Count down while running, reload and pulse on rollover
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (!run) begin
      r_next.cnt = reload;
    end else if (r_reg.cnt == '0) begin
      r_next.cnt  = reload;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule : imr_brg
`default_nettype wire

// [src/imr_rx.sv]
// Purpose: I2C master receive path with its register file
// Assumes: SCL and SDA inputs already synchronous to clk
// Notes:   Open-drain pins; an enable low pulls the line low
//
// Summary of operation
// [RQ1] Setting receive enable starts a byte reception
// [RQ2] Receive enable ignored unless module idle
// [RQ3] Each rollover toggles SCL; each falling edge shifts SDA in
// [RQ4] Receive enable clears after eighth falling edge
// [RQ5] Finished byte loads buffer, sets full, interrupt
// [RQ6] Then generator stops, SCL held low, idle
// [RQ7] Reading the buffer clears buffer full
// [RQ8] Ack enable sends acknowledge after reception
// [RQ9] Eighth bit with buffer full sets overflow
// [RQ10] Buffer write while busy sets collision, ignored
// [RQ11] Interrupt flag also set after ack completes
// [RQ12] No command queueing; busy commands are dropped
// [RQ13] Software clears write collision flag itself
// [RQ14] Overflow keeps old buffer, flag stays set
// [RQ15] Slave changes SDA only while SCL low
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module imr_rx
  import imr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [DATA_W-1:0] rdata,
  // Interrupt
  output var  logic              irq,
  // I2C clock pin
  input  wire logic              scl_in,
  output var  logic              scl_out,
  output var  logic              scl_oe_n,
  // I2C data pin
  input  wire logic              sda_in,
  output var  logic              sda_out,
  output var  logic              sda_oe_n
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    imr_state_t  st;
    logic [2:0]  bit_cnt;
    logic [7:0]  shreg;     // shift_register
    logic [7:0]  tbuf;      // transfer_buffer
    logic        receive_enable_bit;      // receive_enable_bit
    logic        ack_sequence_enable;     // ack_sequence_enable
    logic        ack_val;
    logic        bf;        // buffer_full_flag
    logic        irqf;      // serial_irq_flag
    logic        ovf;       // receive_overflow_flag
    logic        write_collision_flag;      // write_collision_flag
    logic [7:0]  mask;
    logic [7:0]  brg;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic [7:0]  rdata;
    logic        irq;
  } imr_rx_regs_t;

  imr_rx_regs_t r_reg;
  imr_rx_regs_t r_next;

  logic brg_tick;
  logic busy;
  logic byte_done;
  logic ack_done;
  logic wr_ctrl;
  logic wr_buf;
  logic wr_stat;
  logic rd_buf;

  // Appends the sampled data bit to the shift register
  function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                          input logic       b);
    return {sr[6:0], b};
  endfunction : shift_in

  // ---------------------------------------------------------------
  // Baud rate generator
  // ---------------------------------------------------------------
  imr_brg #(
    .W (DATA_W)
  ) u_brg (
    .clk    (clk),
    .rstn   (rstn),
    .run    (busy),
    .reload (r_reg.brg),
    .tick   (brg_tick)
  );

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  assign busy    = (r_reg.st != ST_IDLE);
  assign wr_ctrl = wr && (addr == OFS_CTRL);
  assign wr_buf  = wr && (addr == OFS_BUF);
  assign wr_stat = wr && (addr == OFS_STAT);
  assign rd_buf  = rd && (addr == OFS_BUF);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    r_next    = r_reg;
    byte_done = 1'b0;
    ack_done  = 1'b0;

    // Write-one-to-clear of sticky flags; events below win
    if (wr_stat) begin
      if (wdata[STAT_IRQ]) begin
        r_next.irqf = 1'b0;
      end
      if (wdata[STAT_OVF]) begin
        r_next.ovf = 1'b0;               // [RQ14]
      end
      if (wdata[STAT_WRITE_COLLISION_FLAG]) begin
        r_next.write_collision_flag = 1'b0;              // [RQ13]
      end
    end

    // Plain configuration registers
    if (wr && addr == OFS_MASK) begin
      r_next.mask = wdata;
    end
    if (wr && addr == OFS_BRG) begin
      r_next.brg = wdata;
    end

    // Buffer read empties it
    if (rd_buf) begin
      r_next.bf = 1'b0;                  // [RQ7]
    end

    // Buffer write collides with a byte in flight
    if (wr_buf) begin
      if (busy) begin
        r_next.write_collision_flag = 1'b1;              // [RQ10]
      end else begin
        r_next.tbuf = wdata;
      end
    end

    // Commands are taken only while idle
    if (wr_ctrl) begin
      r_next.ack_val = busy ? r_reg.ack_val : wdata[CTRL_ACKVAL]; // [RQ12]
      if (!busy && wdata[CTRL_RECEIVE_ENABLE_BIT]) begin // [RQ2]
        r_next.receive_enable_bit     = 1'b1;          // [RQ1]
        r_next.st       = ST_RX_LOW;
        r_next.bit_cnt  = FIRST_BIT;
        r_next.scl_oe_n = 1'b0;
        r_next.sda_oe_n = 1'b1;
      end else if (!busy && wdata[CTRL_ACK_SEQUENCE_ENABLE]) begin
        r_next.ack_sequence_enable    = 1'b1;          // [RQ8]
        r_next.st       = ST_ACK_LOW;
        r_next.scl_oe_n = 1'b0;
        r_next.sda_oe_n = wdata[CTRL_ACKVAL];
      end
    end

    // Bus sequencer, one step per generator rollover
    unique case (r_reg.st)
      ST_IDLE: begin
        // Waits for software; SCL stays where the last step left it
      end
      ST_RX_LOW: begin
        if (brg_tick) begin
          r_next.scl_oe_n = 1'b1;        // [RQ3]
          r_next.st       = ST_RX_HIGH;
        end
      end
      ST_RX_HIGH: begin
        if (brg_tick) begin
          r_next.scl_oe_n = 1'b0;        // [RQ3]
          r_next.shreg    = shift_in(r_reg.shreg, sda_in); // [RQ15]
          r_next.bit_cnt  = 3'(r_reg.bit_cnt + 3'h1);
          r_next.st       = ST_RX_LOW;
          if (r_reg.bit_cnt == LAST_BIT) begin
            byte_done   = 1'b1;
            r_next.receive_enable_bit = 1'b0;          // [RQ4]
            r_next.st   = ST_IDLE;       // [RQ6]
          end
        end
      end
      ST_ACK_LOW: begin
        if (brg_tick) begin
          r_next.scl_oe_n = 1'b1;        // [RQ8]
          r_next.st       = ST_ACK_HIGH;
        end
      end
      ST_ACK_HIGH: begin
        if (brg_tick) begin
          r_next.scl_oe_n = 1'b0;
          r_next.st       = ST_ACK_END;
        end
      end
      ST_ACK_END: begin
        if (brg_tick) begin
          ack_done        = 1'b1;
          r_next.sda_oe_n = 1'b1;
          r_next.ack_sequence_enable    = 1'b0;
          r_next.st       = ST_IDLE;
        end
      end
      default: begin
        r_next.st       = ST_IDLE;
        r_next.scl_oe_n = 1'b1;
        r_next.sda_oe_n = 1'b1;
      end
    endcase

    // Byte completion: load or overflow, then flag
    if (byte_done) begin
      if (r_reg.bf) begin
        r_next.ovf = 1'b1;               // [RQ9]
      end else begin
        r_next.tbuf = shift_in(r_reg.shreg, sda_in); // [RQ5]
        r_next.bf   = 1'b1;              // [RQ5]
      end
      r_next.irqf = 1'b1;                // [RQ5]
    end
    if (ack_done) begin
      r_next.irqf = 1'b1;                // [RQ11]
    end

    // Read data stand for one cycle only
    r_next.rdata = RST_ZERO;
    if (rd) begin
      unique case (addr)
        OFS_CTRL: begin
          r_next.rdata[CTRL_RECEIVE_ENABLE_BIT]   = r_reg.receive_enable_bit;
          r_next.rdata[CTRL_ACK_SEQUENCE_ENABLE]  = r_reg.ack_sequence_enable;
          r_next.rdata[CTRL_ACKVAL] = r_reg.ack_val;
        end
        OFS_BUF: begin
          r_next.rdata = r_reg.tbuf;
        end
        OFS_STAT: begin
          r_next.rdata[STAT_BF]   = r_reg.bf;
          r_next.rdata[STAT_IRQ]  = r_reg.irqf;
          r_next.rdata[STAT_OVF]  = r_reg.ovf;
          r_next.rdata[STAT_WRITE_COLLISION_FLAG] = r_reg.write_collision_flag;
          r_next.rdata[STAT_BUSY] = busy;
        end
        OFS_MASK: begin
          r_next.rdata = r_reg.mask;
        end
        OFS_BRG: begin
          r_next.rdata = r_reg.brg;
        end
        default: begin
          r_next.rdata = RST_ZERO;       // Unmapped reads as zero
        end
      endcase
    end

    // Level interrupt from unmasked sticky flags
    r_next.irq = (r_next.irqf && r_next.mask[STAT_IRQ])
              || (r_next.ovf  && r_next.mask[STAT_OVF])
              || (r_next.write_collision_flag && r_next.mask[STAT_WRITE_COLLISION_FLAG]);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg          <= '0;
      r_reg.st       <= ST_IDLE;
      r_reg.brg      <= RST_BRG;
      r_reg.scl_oe_n <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops, pin levels tied to zero; pins only ever pull low
  assign rdata    = r_reg.rdata;
  assign irq      = r_reg.irq;
  assign scl_oe_n = r_reg.scl_oe_n;
  assign sda_oe_n = r_reg.sda_oe_n;
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic unused_scl;
  assign unused_scl = scl_in;

  sequence s_last_fall;
    (r_reg.st == ST_RX_HIGH) && brg_tick && (r_reg.bit_cnt == LAST_BIT);
  endsequence

  sequence s_go_idle_low;
    (r_reg.st == ST_IDLE) && !r_reg.receive_enable_bit && !r_reg.scl_oe_n;
  endsequence

  a_rx_start: assert property ( // [RQ1]
    (!busy && wr_ctrl && wdata[CTRL_RECEIVE_ENABLE_BIT]) |=>
      (r_reg.st == ST_RX_LOW) && r_reg.receive_enable_bit && !r_reg.scl_oe_n)
    else $error("reception did not start on receive enable");

  a_busy_ignore: assert property ( // [RQ2]
    (busy && wr_ctrl && r_reg.st != ST_ACK_END) |=>
      ($stable(r_reg.ack_sequence_enable) || !r_reg.ack_sequence_enable) && !$rose(r_reg.receive_enable_bit))
    else $error("command taken while busy");

  a_scl_toggle: assert property ( // [RQ3]
    (brg_tick && (r_reg.st == ST_RX_LOW || r_reg.st == ST_RX_HIGH)) |=>
      (r_reg.scl_oe_n != $past(r_reg.scl_oe_n)))
    else $error("SCL not toggled on rollover");

  a_rx_finish: assert property ( // [RQ4]
    s_last_fall |=> s_go_idle_low ##1 (r_reg.st inside {ST_IDLE, ST_RX_LOW, ST_ACK_LOW})[*2])
    else $error("receiver did not stop after eighth bit");

  a_buf_load: assert property ( // [RQ5]
    (s_last_fall and !r_reg.bf) |=>
      r_reg.bf && r_reg.irqf && (r_reg.tbuf == $past(shift_in(r_reg.shreg, sda_in))))
    else $error("buffer not loaded on byte completion");

  a_bf_read_clr: assert property ( // [RQ7]
    (rd_buf && !byte_done) |=> !r_reg.bf)
    else $error("buffer read did not clear full flag");

  a_ack_drive: assert property ( // [RQ8]
    (r_reg.st == ST_ACK_HIGH) |-> (r_reg.sda_oe_n == r_reg.ack_val) && r_reg.ack_sequence_enable)
    else $error("ack level not driven during ack clock");

  a_overflow: assert property ( // [RQ9]
    (s_last_fall and r_reg.bf) |=>
      r_reg.ovf && $stable(r_reg.tbuf) && r_reg.irqf)
    else $error("overflow not flagged or buffer overwritten");

  a_write_collision_flag_set: assert property ( // [RQ10]
    (wr_buf && busy && !byte_done) |=> r_reg.write_collision_flag && $stable(r_reg.tbuf))
    else $error("collision write changed buffer");

  a_ack_irq: assert property ( // [RQ11]
    ((r_reg.st == ST_ACK_END) && brg_tick) |=>
      r_reg.irqf && !r_reg.ack_sequence_enable && r_reg.sda_oe_n)
    else $error("ack completion not flagged");

  a_ovf_hold: assert property ( // [RQ14]
    (r_reg.ovf && !(wr_stat && wdata[STAT_OVF])) |=> r_reg.ovf)
    else $error("overflow flag lost without a clear");

endmodule : imr_rx
`default_nettype wire

// [sim/imr_slave_model.sv]
// Purpose: Simple I2C slave, with no address, that sends bytes to the receiver
// Assumes: SCL and SDA are wired-AND lines with pull-ups
// Notes:   A byte of 8'hFF leaves SDA released for the ack slot
`timescale 1ns/1ps
`default_nettype none
module imr_slave_model (
  // Bus lines
  input  wire logic       scl,
  output var  logic       sda_oe_n,
  // Bench control
  input  wire logic       load,
  input  wire logic [7:0] byte_in
);
  logic [7:0] data_reg = 8'hFF;
  logic [2:0] bit_reg  = 3'h0;
  logic       high_reg = 1'b0;

  // Reload happens on any rising edge of load, whatever the level of SCL
  always @(posedge load) begin
    data_reg = byte_in;
    bit_reg  = 3'h0;
    high_reg = 1'b0;
  end

  // Note each rise of SCL, the start of a high phase
  always @(posedge scl) begin
    high_reg = 1'b1;
  end

  // Move to the next bit only after a fall, never while SCL is high
  always @(negedge scl) begin
    if (high_reg) begin
      bit_reg  = bit_reg + 3'h1;
      high_reg = 1'b0;
    end
  end

  // MSB first; a one releases the line to its pull-up
  assign sda_oe_n = data_reg[3'h7 - bit_reg];
endmodule : imr_slave_model
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the I2C master byte receiver
// Assumes: Wired-AND bus with pull-ups, no clock stretching
// Notes:   Short baud reload keeps each byte near 70 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import imr_pkg::*;
  logic              clk;
  logic              rstn;
  logic              wr;
  logic              rd;
  logic              load;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [7:0]        slv_byte;
  logic              irq;
  logic              scl_out;
  logic              scl_oe_n;
  logic              sda_out;
  logic              sda_oe_n;
  logic              slv_oe_n;
  logic [7:0]        rv;
  wire logic         scl;
  wire logic         sda;
  int                failures;
  int                tests_run;
  int                highs;

  // Open-drain lines with pull-ups
  assign scl = scl_oe_n ? 1'b1 : scl_out;
  assign sda = (sda_oe_n ? 1'b1 : sda_out) & slv_oe_n;

  imr_rx dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  imr_slave_model slave (.scl(scl), .sda_oe_n(slv_oe_n), .load(load), .byte_in(slv_byte));

  // Clock and SCL high-phase counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge scl) highs++;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      rd_reg(OFS_STAT, rv);
      if (rv[STAT_BUSY] === 1'b0) return;
    end
    failures++;
    complete_run();
  endtask : wait_idle

  task automatic start_rx(input logic [7:0] b);
    slv_byte = b; load = 1'b1;
    #1 load = 1'b0;
    highs = 0;
    wr_reg(OFS_CTRL, 8'h08);
  endtask : start_rx

  task automatic t_reset();
    check("scl idle", scl_oe_n, 8'h01);
    check("irq idle", irq, 8'h00);
    rd_reg(OFS_STAT, rv); check("stat rst", rv, RST_ZERO);
    rd_reg(OFS_MASK, rv); check("mask rst", rv, RST_ZERO);
    rd_reg(OFS_BRG, rv);  check("brg rst", rv, RST_BRG);
    rd_reg(3'h7, rv);     check("unmapped", rv, 8'h00);
  endtask : t_reset

  task automatic t_receive();
    wr_reg(OFS_MASK, 8'h0E);
    wr_reg(OFS_BRG, 8'h03);
    start_rx(8'hA5);
    rd_reg(OFS_STAT, rv); check("busy", rv & 8'h10, 8'h10);
    wr_reg(OFS_BUF, 8'h3C);
    wr_reg(OFS_CTRL, 8'h08);
    wait_idle();
    repeat (20) @(posedge clk);
    check("scl highs", highs[7:0], 8'h08);
    check("scl low", scl_oe_n, 8'h00);
    rd_reg(OFS_CTRL, rv); check("receive_enable_bit", rv & 8'h08, 8'h00);
    rd_reg(OFS_STAT, rv); check("stat rx", rv, 8'h0B);
    check("irq set", irq, 8'h01);
    rd_reg(OFS_BUF, rv);  check("buffer", rv, 8'hA5);
    rd_reg(OFS_STAT, rv); check("bf clr", rv, 8'h0A);
    wr_reg(OFS_STAT, 8'h0A);
    rd_reg(OFS_STAT, rv); check("w1c", rv, 8'h00);
    check("irq clr", irq, 8'h00);
  endtask : t_receive

  task automatic t_overflow();
    start_rx(8'h3C);
    wait_idle();
    start_rx(8'hC3);
    wr_reg(OFS_BUF, 8'h55);
    wait_idle();
    rd_reg(OFS_STAT, rv); check("ovf", rv, 8'h0F);
    rd_reg(OFS_BUF, rv);  check("kept", rv, 8'h3C);
    rd_reg(OFS_STAT, rv); check("ovf held", rv, 8'h0E);
    wr_reg(OFS_STAT, 8'h0E);
    rd_reg(OFS_STAT, rv); check("ovf clr", rv, 8'h00);
  endtask : t_overflow

  task automatic t_ack();
    slv_byte = 8'hFF; load = 1'b1;
    #1 load = 1'b0;
    wr_reg(OFS_CTRL, 8'h10);
    for (int i = 0; i < 100 && scl !== 1'b1; i++) @(posedge clk);
    check("ack scl", scl, 8'h01);
    check("ack level", sda, 8'h00);
    wait_idle();
    rd_reg(OFS_CTRL, rv); check("ack_sequence_enable", rv & 8'h10, 8'h00);
    rd_reg(OFS_STAT, rv); check("ack irq", rv, 8'h02);
    check("irq ack", irq, 8'h01);
    wr_reg(OFS_MASK, 8'h00);
    rd_reg(OFS_STAT, rv);
    check("irq masked", irq, 8'h00);
    // Negative acknowledge leaves SDA released in the ack slot
    wr_reg(OFS_STAT, 8'h02);
    wr_reg(OFS_CTRL, 8'h30);
    for (int i = 0; i < 100 && scl !== 1'b1; i++) @(posedge clk);
    check("nack scl", scl, 8'h01);
    check("nack level", sda, 8'h01);
    wait_idle();
    rd_reg(OFS_CTRL, rv); check("nack ctrl", rv, 8'h20);
    rd_reg(OFS_STAT, rv); check("nack irq", rv, 8'h02);
  endtask : t_ack

  // Main sequence
  initial begin
    failures = 0; tests_run = 0; highs = 0;
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; load = 1'b0;
    addr = 3'h0; wdata = 8'h00; slv_byte = 8'hFF;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_receive();
    t_overflow();
    t_ack();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
